// *** bench/pad_side_model.sv ***
// Pads and peripheral lanes beside the two pins.
// The bench sets the level that the outside world puts on each pad.
`timescale 1ns/1ps
`default_nettype none
module pad_side_model
    import pin_ctrl_pkg::*;
(
    // Commanded by the bench
    input wire logic [NUM_PINS-1:0] ext_level,
    // Pads
    input wire logic [NUM_PINS-1:0] pad_out,
    input wire logic [NUM_PINS-1:0] pad_oe,
    output logic [NUM_PINS-1:0] pad_in,
    // Peripheral lanes
    output logic [NUM_PINS-1:0][FUNC_COUNT-1:0] func_out,
    output logic [NUM_PINS-1:0][FUNC_COUNT-1:0] func_oe
);
    // Complementary lane patterns on the two pins, so each code gives them opposite levels
    assign func_out = {9'h14a, 9'h0b5};
    // Lane 0 never drives, so a pad enable there is a fault
    assign func_oe = {9'h1fe, 9'h1fe};
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule
`default_nettype wire

// *** bench/pin_ctrl_checker.sv ***
// Port-level checks for the two-pin control block.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pin_ctrl_checker
    import pin_ctrl_pkg::*;
(
    // Clock, reset, bus
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pad side
    input wire logic [NUM_PINS-1:0] pad_oe,
    input wire logic [NUM_PINS-1:0][DRIVE_W-1:0] pad_drive_strength,
    input wire logic [NUM_PINS-1:0] output_driver_enable,
    input wire logic [NUM_PINS-1:0] schmitt_input_enable,
    input wire logic converter_channel_five
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_oe_gated: assert property (
        pad_oe[0] |-> $past(output_driver_enable[0])) else $error("pad driven while off");
    a_analog_off: assert property (
        converter_channel_five && $past(converter_channel_five) |-> !pad_oe[0])
        else $error("pad driven in analog use");
    // Own disable: the antecedent is the reset itself
    a_reset_vals: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> pad_drive_strength == 6'h09 && output_driver_enable == 2'h0 &&
        schmitt_input_enable == 2'h0) else $error("bad pad reset state");
endmodule
`default_nettype wire

bind pin_control_irq_mux pin_ctrl_checker i_checker (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pad_oe(pad_oe), .pad_drive_strength(pad_drive_strength),
    .output_driver_enable(output_driver_enable), .schmitt_input_enable(schmitt_input_enable),
    .converter_channel_five(converter_channel_five));

// *** bench/test_pin_control_irq_mux.sv ***
// Self-checking bench for the two-pin control block.
// Drives the register bus and pad levels; a monitor checks bus answers.
`timescale 1ns/1ps
`default_nettype none
module test_pin_control_irq_mux import pin_ctrl_pkg::*;;
    localparam logic [7:0] C0 = PIN21_CONTROL_OFFSET;
    localparam logic [7:0] C1 = PIN22_CONTROL_OFFSET;
    localparam logic [7:0] ST = IRQ_STATUS_OFFSET;
    localparam logic [7:0] MK = IRQ_MASK_OFFSET;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] ext = 0, pad_in, pad_out, pad_oe, req, bresp, rresp, spu, wpd, ien, oen, smt;
    logic awready, wready, bvalid, arready, rvalid, irq, cv5, cv6, wpu, mpu, lvl, p;
    logic [1:0][2:0] drv;
    logic [1:0][8:0] fo, foe, fi;
    logic [8:0] so, se;
    logic [33:0] exp_q[$];
    int num_errors = 0, compares = 0;

    always #4 aclk = ~aclk;

    pin_control_irq_mux i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_drive_strength(drv), .strong_pullup_enable(spu),
        .weak_pulldown_enable(wpd), .weak_pullup_enable(wpu), .medium_pullup_enable(mpu),
        .input_buffer_enable(ien), .output_driver_enable(oen), .schmitt_input_enable(smt),
        .func_out(fo), .func_oe(foe), .func_in(fi), .converter_channel_five(cv5),
        .converter_channel_six(cv6), .interrupt_controller_request(req), .irq(irq));

    pad_side_model i_pads (.ext_level(ext), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_in(pad_in), .func_out(fo), .func_oe(foe));

    task automatic check(logic [33:0] seen, logic [33:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        exp_q.push_back({r, 32'h0});
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
    endtask

    task automatic rd(logic [7:0] a, logic [33:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        exp_q.push_back(e);
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
    endtask

    // Oldest note meets each answer as it is taken
    always @(posedge aclk) begin
        if (bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
        if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
    end

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        stop_test();
    end

    initial begin
        d = $urandom(52861);
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rd(C0, 34'h1001);
        rd(C1, 34'h1001);
        rd(ST, 34'h0);
        check({drv, spu, wpd, ien, oen, smt, wpu, mpu}, 18'h09000);
        $display("done reset");
        wr(C0, '1, 2'h0);
        rd(C0, 34'h02f07bff);
        // Pins hold separate channels, never a shared one
        wr(C1, '1, 2'h0);
        check({drv, spu, wpd, ien, oen, smt, wpu, mpu, cv5, cv6}, 20'hfffff);
        repeat (4) begin
            d = $urandom;
            ext[1] <= d[7];
            wr(C1, d, 2'h0);
            rd(C1, {2'h0, d & 32'h02f07bff});
        end
        wr(8'h70, d, 2'h2);
        rd(8'h70, {2'h2, 32'h0});
        wr(C1, 32'h1001, 2'h0);
        $display("done fields");
        for (int m = 0; m < 6; m++) begin
            lvl = (m == 1 || m == 4);
            ext[0] <= lvl;
            wr(C0, 32'h0210_1001 | (32'(m) << 21), 2'h0);
            repeat (4) @(posedge aclk);
            wr(ST, 32'h3, 2'h0);
            rd(ST, 34'h0);
            ext[0] <= !lvl;
            repeat (5) @(posedge aclk);
            p = (m < 5);
            check(req, {1'b0, p});
            wr(ST, 32'h1, 2'h0);
            rd(ST, {33'h0, p && m > 2});
        end
        ext[0] <= 0;
        wr(C0, 32'h0010_1001, 2'h0);
        repeat (4) @(posedge aclk);
        wr(ST, 32'h3, 2'h0);
        ext[0] <= 1;
        repeat (5) @(posedge aclk);
        check({req, irq}, 3'h0);
        rd(ST, 34'h1);
        wr(MK, 32'h1, 2'h0);
        check(irq, 1);
        wr(ST, 32'h1, 2'h0);
        check(irq, 0);
        wr(C0, 32'h0200_1001, 2'h0);
        ext[0] <= 0;
        repeat (5) @(posedge aclk);
        ext[0] <= 1;
        repeat (5) @(posedge aclk);
        rd(ST, 34'h0);
        check(req, 2'h0);
        $display("done events");
        for (int f = 0; f < 10; f++) begin
            wr(C0, 32'h10c0 | f, 2'h0);
            wr(C1, 32'h10c0 | f, 2'h0);
            repeat (6) @(posedge aclk);
            for (int k = 0; k < 2; k++) begin
                so = fo[k] >> f;
                se = foe[k] >> f;
                lvl = se[0] ? so[0] : ext[k];
                check({pad_oe[k], pad_out[k] & pad_oe[k]}, {se[0], so[0] & se[0]});
                // Cut to the lane width so code 9 expects no lane at all
                check(fi[k], 9'({8'h0, lvl} << f));
            end
        end
        wr(C0, 32'h10d1, 2'h0);
        repeat (6) @(posedge aclk);
        check({cv5, pad_oe[0], fi[0]}, {2'b10, 9'h0});
        $display("done mux");
        stop_test();
    end
endmodule
`default_nettype wire

// *** src/pin_control_irq_mux.sv ***
// Control registers, function multiplexing and interrupt logic for two pins.
// Assumes an AXI4-Lite master on aclk and asynchronous pad inputs.
//
// How it works
// - Trigger field picks rising, falling, both edges, high or low level.
// - Interrupt enable set: detected trigger sets the pin pending flag.
// - Interrupt enable clear: no pending set, no request forwarded.
// - Forward mask bit gates pending requests toward the interrupt controller.
// - Function select routes pin among nine functions; 0x1 after reset.
// - Analog select hands the pin to its converter channel instead.
// - Three-bit drive strength code, resets to code 001.
// - First pin: bit 8 enables its weak pull-up.
// - Schmitt input enable bit, reset disabled.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pin_control_irq_mux
    import pin_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads: index 0 is the first pin, index 1 the second
    input wire logic [NUM_PINS-1:0] pad_in,
    output logic [NUM_PINS-1:0] pad_out,
    output logic [NUM_PINS-1:0] pad_oe,
    // Pad configuration
    output logic [NUM_PINS-1:0][DRIVE_W-1:0] pad_drive_strength,
    output logic [NUM_PINS-1:0] strong_pullup_enable,
    output logic [NUM_PINS-1:0] weak_pulldown_enable,
    output logic weak_pullup_enable,
    output logic medium_pullup_enable,
    output logic [NUM_PINS-1:0] input_buffer_enable,
    output logic [NUM_PINS-1:0] output_driver_enable,
    output logic [NUM_PINS-1:0] schmitt_input_enable,
    // Peripheral functions, one lane per function code
    input wire logic [NUM_PINS-1:0][FUNC_COUNT-1:0] func_out,
    input wire logic [NUM_PINS-1:0][FUNC_COUNT-1:0] func_oe,
    output logic [NUM_PINS-1:0][FUNC_COUNT-1:0] func_in,
    // Analog converter connections
    output logic converter_channel_five,
    output logic converter_channel_six,
    // Interrupts
    output logic [NUM_PINS-1:0] interrupt_controller_request,
    output logic irq
);

    typedef struct packed {
        logic [NUM_PINS-1:0][31:0] ctrl;
        logic [NUM_PINS-1:0] irq_mask;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic [NUM_PINS-1:0] pad_out;
        logic [NUM_PINS-1:0] pad_oe;
        logic [NUM_PINS-1:0][FUNC_COUNT-1:0] func_in;
    } top_state_t;

    localparam top_state_t STATE_RESET = '{
        ctrl: {CONTROL_RESET, CONTROL_RESET},
        irq_mask: IRQ_MASK_RESET,
        default: '0
    };

    top_state_t state_reg;
    top_state_t state_next;
    logic [NUM_PINS-1:0] pending;
    logic [NUM_PINS-1:0] pending_clear;
    logic [NUM_PINS-1:0] forward_req;
    logic write_fire;
    logic [31:0] strb_mask;

    // Byte lanes to bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            strb_mask[b*8 +: 8] = {8{state_reg.w_strb[b]}};
        end
    end

    assign write_fire = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;

    // W1C on the status register; applied inside the event units
    always_comb begin
        pending_clear = '0;
        if (write_fire && state_reg.aw_addr == IRQ_STATUS_OFFSET) begin
            pending_clear = state_reg.w_data[NUM_PINS-1:0] & strb_mask[NUM_PINS-1:0];
        end
    end

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        pin_event_unit u_event (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_level(state_reg.sync2[p]),
            .trigger_mode_select(state_reg.ctrl[p][TRIG_LSB +: TRIG_W]),
            .pin_irq_enable(state_reg.ctrl[p][IRQ_ENABLE_BIT]),
            .irq_forward_mask(state_reg.ctrl[p][FORWARD_MASK_BIT]),
            .pending_clear(pending_clear[p]),
            .pending(pending[p]),
            .irq_request(forward_req[p])
        );
    end

    always_comb begin
        logic [31:0] merged;
        logic [FUNC_W-1:0] sel;
        logic [ADDR_W-1:0] ra;
        merged = '0;
        sel = '0;
        ra = s_axi_araddr;
        state_next = state_reg;

        // Pad inputs cross into aclk through two flops
        state_next.sync1 = pad_in;
        state_next.sync2 = state_reg.sync1;

        // Address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_got = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_got = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end

        if (write_fire) begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = RESP_OKAY;
            merged = (state_reg.w_data & strb_mask);
            if (state_reg.aw_addr == PIN21_CONTROL_OFFSET) begin
                state_next.ctrl[0] = ((state_reg.ctrl[0] & ~strb_mask) | merged)
                    & CONTROL_WRITE_MASK;
            end else if (state_reg.aw_addr == PIN22_CONTROL_OFFSET) begin
                state_next.ctrl[1] = ((state_reg.ctrl[1] & ~strb_mask) | merged)
                    & CONTROL_WRITE_MASK;
            end else if (state_reg.aw_addr == IRQ_STATUS_OFFSET) begin
                state_next.bresp = RESP_OKAY;
            end else if (state_reg.aw_addr == IRQ_MASK_OFFSET) begin
                if (state_reg.w_strb[0]) begin
                    state_next.irq_mask = state_reg.w_data[NUM_PINS-1:0];
                end
            end else begin
                state_next.bresp = RESP_SLVERR;
            end
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = RESP_OKAY;
            if (ra == PIN21_CONTROL_OFFSET) begin
                state_next.rdata = state_reg.ctrl[0];
            end else if (ra == PIN22_CONTROL_OFFSET) begin
                state_next.rdata = state_reg.ctrl[1];
            end else if (ra == IRQ_STATUS_OFFSET) begin
                state_next.rdata = {30'h0, pending};
            end else if (ra == IRQ_MASK_OFFSET) begin
                state_next.rdata = {30'h0, state_reg.irq_mask};
            end else begin
                state_next.rdata = '0;
                state_next.rresp = RESP_SLVERR;
            end
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        // Function routing, registered toward pad and peripherals
        for (int p = 0; p < NUM_PINS; p++) begin
            sel = state_reg.ctrl[p][FUNC_LSB +: FUNC_W];
            state_next.pad_out[p] = 1'b0;
            state_next.pad_oe[p] = 1'b0;
            state_next.func_in[p] = '0;
            // Analog use takes the pad away from every digital function
            if (!state_reg.ctrl[p][ANALOG_BIT] && sel <= FUNC_LAST) begin
                state_next.pad_out[p] = func_out[p][sel];
                state_next.pad_oe[p] = func_oe[p][sel]
                    & state_reg.ctrl[p][OUTPUT_EN_BIT];
                state_next.func_in[p][sel] = state_reg.sync2[p]
                    & state_reg.ctrl[p][INPUT_EN_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus handshakes
    assign s_axi_awready = ~state_reg.aw_got & ~state_reg.bvalid;
    assign s_axi_wready = ~state_reg.w_got & ~state_reg.bvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = ~state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    // Pad side
    assign pad_out = state_reg.pad_out;
    assign pad_oe = state_reg.pad_oe;
    assign func_in = state_reg.func_in;

    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            pad_drive_strength[p] = state_reg.ctrl[p][DRIVE_LSB +: DRIVE_W];
            strong_pullup_enable[p] = state_reg.ctrl[p][STRONG_PU_BIT];
            weak_pulldown_enable[p] = state_reg.ctrl[p][WEAK_PD_BIT];
            input_buffer_enable[p] = state_reg.ctrl[p][INPUT_EN_BIT];
            output_driver_enable[p] = state_reg.ctrl[p][OUTPUT_EN_BIT];
            schmitt_input_enable[p] = state_reg.ctrl[p][SCHMITT_BIT];
        end
    end

    // Same bit, different resistor on each pin
    assign weak_pullup_enable = state_reg.ctrl[0][PULLUP_BIT];
    assign medium_pullup_enable = state_reg.ctrl[1][PULLUP_BIT];

    // Fixed mapping: first pin to channel five, second pin to channel six
    assign converter_channel_five = state_reg.ctrl[0][ANALOG_BIT];
    assign converter_channel_six = state_reg.ctrl[1][ANALOG_BIT];

    assign interrupt_controller_request = forward_req;
    assign irq = |(pending & state_reg.irq_mask);

endmodule
`default_nettype wire

// *** src/pin_ctrl_pkg.sv ***
// Constants for the two-pin control and interrupt block.
// Shared by the top module and the per-pin event unit.
package pin_ctrl_pkg;

    localparam int NUM_PINS = 2;
    localparam int FUNC_COUNT = 9;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] PIN21_CONTROL_OFFSET = 8'h60;
    localparam logic [ADDR_W-1:0] PIN22_CONTROL_OFFSET = 8'h64;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 8'h68;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 8'h6c;

    // Control register field positions
    localparam int FORWARD_MASK_BIT = 25;
    localparam int TRIG_LSB = 21;
    localparam int TRIG_W = 3;
    localparam int IRQ_ENABLE_BIT = 20;
    localparam int DRIVE_LSB = 12;
    localparam int DRIVE_W = 3;
    localparam int STRONG_PU_BIT = 11;
    localparam int WEAK_PD_BIT = 9;
    localparam int PULLUP_BIT = 8;
    localparam int INPUT_EN_BIT = 7;
    localparam int OUTPUT_EN_BIT = 6;
    localparam int SCHMITT_BIT = 5;
    localparam int ANALOG_BIT = 4;
    localparam int FUNC_LSB = 0;
    localparam int FUNC_W = 4;

    // Reset value: drive code 001, function code 0x1, all else zero
    localparam logic [31:0] CONTROL_RESET = 32'h0000_1001;
    // Writable bits; reserved 31:26, 24, 19:15 and 10 stay zero
    localparam logic [31:0] CONTROL_WRITE_MASK = 32'h02f0_7bff;
    localparam logic [NUM_PINS-1:0] IRQ_MASK_RESET = 2'h0;

    // Trigger mode codes
    localparam logic [TRIG_W-1:0] TRIG_RISE = 3'h0;
    localparam logic [TRIG_W-1:0] TRIG_FALL = 3'h1;
    localparam logic [TRIG_W-1:0] TRIG_BOTH = 3'h2;
    localparam logic [TRIG_W-1:0] TRIG_HIGH = 3'h3;
    localparam logic [TRIG_W-1:0] TRIG_LOW = 3'h4;

    localparam logic [FUNC_W-1:0] FUNC_LAST = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** src/pin_event_unit.sv ***
// Trigger detection and pending flag for one pin.
// Expects a pin level already synchronised to aclk.
`timescale 1ns/1ps
`default_nettype none
module pin_event_unit
    import pin_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin and control
    input wire logic pin_level,
    input wire logic [TRIG_W-1:0] trigger_mode_select,
    input wire logic pin_irq_enable,
    input wire logic irq_forward_mask,
    input wire logic pending_clear,
    // Results
    output logic pending,
    output logic irq_request
);

    typedef struct packed {
        logic armed;
        logic prev;
        logic pending;
    } event_state_t;

    event_state_t state_reg;
    event_state_t state_next;
    logic hit;

    always_comb begin
        state_next = state_reg;
        state_next.prev = pin_level;
        state_next.armed = 1'b1;
        // Edges are only trusted once a previous sample exists
        case (trigger_mode_select)
            TRIG_RISE: hit = state_reg.armed & pin_level & ~state_reg.prev;
            TRIG_FALL: hit = state_reg.armed & ~pin_level & state_reg.prev;
            TRIG_BOTH: hit = state_reg.armed & (pin_level ^ state_reg.prev);
            TRIG_HIGH: hit = pin_level;
            TRIG_LOW: hit = ~pin_level;
            default: hit = 1'b0;
        endcase
        if (pending_clear) begin
            state_next.pending = 1'b0;
        end
        // Set wins over a clear in the same cycle; level modes re-set every cycle
        if (pin_irq_enable && hit) begin
            state_next.pending = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pending = state_reg.pending;
    assign irq_request = state_reg.pending & pin_irq_enable & irq_forward_mask;

endmodule
`default_nettype wire
